/* verilog/jsa_pkg.sv */
// Purpose: shared constants and types for the jump/shift/add executor
// Assumes: 8-bit words, 12-bit addresses, 125 MHz clock
// Notes: opcode values are given in hex
`default_nettype none
package jsa_pkg;
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned T_SHORT_NS = 4000;
  localparam int unsigned T_JUMP_NS = 8000;
  localparam int unsigned T_MEM_NS = 12000;
  localparam int unsigned T_IND_NS = 16000;
  localparam logic [11:0] CYC_SHORT = 12'((T_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CYC_JUMP = 12'((T_JUMP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CYC_MEM = 12'((T_MEM_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CYC_IND = 12'((T_IND_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] TAG_RESET = 4'h0;
  localparam int unsigned TAG_HI = 7;
  localparam int unsigned TAG_LO = 6;
  localparam int unsigned OP_HI = 5;
  localparam int unsigned SIGN_BIT = 7;
  localparam logic [5:0] OP_SHIFT_LEFT = 6'h01;
  localparam logic [5:0] OP_ADD_IMMEDIATE = 6'h18;
  localparam logic [5:0] OP_ADD_DIRECT = 6'h19;
  localparam logic [5:0] OP_ADD_INDIRECT = 6'h1A;
  localparam logic [5:0] OP_SUBTRACT_IMMEDIATE = 6'h1C;
  localparam logic [5:0] OP_JUMP_IF_ZERO = 6'h30;
  localparam logic [5:0] OP_JUMP_IF_NONZERO = 6'h31;
  localparam logic [5:0] OP_JUMP_IF_POSITIVE = 6'h32;
  localparam logic [5:0] OP_JUMP_IF_NEGATIVE = 6'h33;
  localparam logic [5:0] OP_JUMP_ALWAYS = 6'h34;
  typedef struct packed {
    logic rd;
    logic [11:0] addr;
  } jsa_mem_req_t;
  typedef enum logic [2:0] {
    ST_FETCH1 = 3'b000,
    ST_FETCH2 = 3'b001,
    ST_POINTER = 3'b011,
    ST_OPERAND = 3'b010,
    ST_WAIT = 3'b110
  } jsa_state_t;
endpackage : jsa_pkg
`default_nettype wire

/* verilog/jsa_tag_file.sv */
// Purpose: four-entry tag register store, entry 0 reads as zero
// Assumes: tags written by other instruction logic through the load port
// Notes: read data registered
`timescale 1ns/10ps
`default_nettype none
module jsa_tag_file (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [1:0] wr_sel_i,
  input wire logic [3:0] wr_data_i,
  input wire logic [1:0] rd_sel_i,
  output logic [3:0] rd_data_o
);
  import jsa_pkg::*;
  logic [3:0] tag_reg [1:3];
  genvar g;
  generate
    for (g = 1; g < 4; g++) begin : g_tag
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          tag_reg[g] <= TAG_RESET;
        end else if (wr_i && wr_sel_i == 2'(g)) begin
          tag_reg[g] <= wr_data_i;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || rd_sel_i == 2'h0) begin
      rd_data_o <= TAG_RESET;
    end else begin
      rd_data_o <= tag_reg[rd_sel_i];
    end
  end
endmodule // jsa_tag_file
`default_nettype wire

/* verilog/jsa_exec.sv */
// Purpose: executes jumps, end-around shift, add and subtract immediate
// Assumes: memory answers a read with data in the same cycle the request stands
// Notes: every instruction occupies its documented time in cycles
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RULE1] zero jump branches on accumulator plus zero
// [RULE2] all-ones minus zero does not branch
// [RULE3] target is tag high, second word low
// [RULE4] untaken conditional jump resumes at P+2
// [RULE5] nonzero jump branches unless accumulator plus zero
// [RULE6] positive jump branches when bit 7 clear
// [RULE7] negative jump branches when bit 7 set
// [RULE8] unconditional jump always loads target
// [RULE9] tag select zero gives zero upper bits
// [RULE10] conditional jump four or eight microseconds
// [RULE11] shift rotates left once, four microseconds
// [RULE12] add immediate adds second word, P+2
// [RULE13] add direct reads formed address, twelve microseconds
// [RULE14] add indirect through low pointer, sixteen microseconds
// [RULE15] subtract immediate takes second word, P+2
// [RULE16] accumulator eight bits, tags four bits
// [RULE17] ones complement with end-around carry
// [RULE18] bits 7:6 tag select, 5:0 opcode
module jsa_exec (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic tag_wr_i,
  input wire logic [1:0] tag_wr_sel_i,
  input wire logic [3:0] tag_wr_data_i,
  output jsa_pkg::jsa_mem_req_t mem_req_o,
  output logic [7:0] acc_o,
  output logic [11:0] pc_o,
  output logic done_o,
  output logic illegal_o
);
  import jsa_pkg::*;

  function automatic logic [7:0] oc_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [8:0] t;
    s = {1'b0, a} + {1'b0, b};
    t = {1'b0, s[7:0]} + {8'h00, s[8]};
    return t[7:0]; // [RULE17]
  endfunction

  function automatic logic is_cond_jump(input logic [5:0] op);
    return op == OP_JUMP_IF_ZERO || op == OP_JUMP_IF_NONZERO ||
           op == OP_JUMP_IF_POSITIVE || op == OP_JUMP_IF_NEGATIVE;
  endfunction

  jsa_state_t state_reg;
  logic [7:0] acc_reg;
  logic [11:0] pc_reg;
  logic [5:0] op_reg;
  logic [1:0] tag_sel_reg;
  logic [7:0] word2_reg;
  logic [11:0] cnt_reg;
  logic [11:0] budget_reg;
  logic [11:0] pc_next;
  logic [3:0] tag_val;
  logic [11:0] target;
  logic taken;
  logic rd_reg;
  logic [11:0] addr_reg;
  logic done_reg;
  logic illegal_reg;
  logic [1:0] tag_rd_sel;

  jsa_tag_file u_tags (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr_i(tag_wr_i),
    .wr_sel_i(tag_wr_sel_i),
    .wr_data_i(tag_wr_data_i),
    .rd_sel_i(tag_rd_sel),
    .rd_data_o(tag_val)
  );

  // look ahead at word one so the tag is ready for the second word
  assign tag_rd_sel = (state_reg == ST_FETCH1) ? mem_rdata_i[TAG_HI:TAG_LO] : tag_sel_reg;
  assign target = {tag_val, word2_reg}; // [RULE3] [RULE9] [RULE16]

  always_comb begin
    unique case (op_reg)
      OP_JUMP_IF_ZERO: taken = (acc_reg == 8'h00); // [RULE1] [RULE2]
      OP_JUMP_IF_NONZERO: taken = (acc_reg != 8'h00); // [RULE5]
      OP_JUMP_IF_POSITIVE: taken = !acc_reg[SIGN_BIT]; // [RULE6]
      OP_JUMP_IF_NEGATIVE: taken = acc_reg[SIGN_BIT]; // [RULE7]
      OP_JUMP_ALWAYS: taken = 1'b1; // [RULE8]
      default: taken = 1'b0;
    endcase
  end

  // state sequence and timing
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= ST_FETCH1;
      cnt_reg <= 12'h000;
      budget_reg <= CYC_SHORT;
    end else begin
      cnt_reg <= (state_reg == ST_FETCH1) ? 12'h001 : cnt_reg + 12'h001;
      unique case (state_reg)
        ST_FETCH1: begin
          if (mem_rdata_i[OP_HI:0] == OP_SHIFT_LEFT) begin
            state_reg <= ST_WAIT;
            budget_reg <= CYC_SHORT; // [RULE11]
          end else begin
            state_reg <= ST_FETCH2;
          end
        end
        ST_FETCH2: begin
          if (op_reg == OP_ADD_INDIRECT) begin
            state_reg <= ST_POINTER;
            budget_reg <= CYC_IND; // [RULE14]
          end else if (op_reg == OP_ADD_DIRECT) begin
            state_reg <= ST_OPERAND;
            budget_reg <= CYC_MEM; // [RULE13]
          end else begin
            state_reg <= ST_WAIT;
            budget_reg <= CYC_SHORT;
          end
        end
        ST_POINTER: state_reg <= ST_OPERAND;
        ST_OPERAND: state_reg <= ST_WAIT;
        ST_WAIT: begin
          if ((is_cond_jump(op_reg) || op_reg == OP_JUMP_ALWAYS) && taken &&
              budget_reg == CYC_SHORT) begin
            budget_reg <= CYC_JUMP; // [RULE10]
          end else if (cnt_reg + 12'h001 >= budget_reg) begin
            state_reg <= ST_FETCH1;
          end
        end
        default: state_reg <= ST_FETCH1;
      endcase
    end
  end

  // instruction word capture
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      op_reg <= 6'h00;
      tag_sel_reg <= 2'h0;
      word2_reg <= 8'h00;
    end else if (state_reg == ST_FETCH1) begin
      op_reg <= mem_rdata_i[OP_HI:0]; // [RULE18]
      tag_sel_reg <= mem_rdata_i[TAG_HI:TAG_LO];
    end else if (state_reg == ST_FETCH2) begin
      word2_reg <= mem_rdata_i;
    end else if (state_reg == ST_POINTER) begin
      word2_reg <= mem_rdata_i; // [RULE14]
    end
  end

  // accumulator
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc_reg <= ACC_RESET;
    end else if (state_reg == ST_FETCH1 && mem_rdata_i[OP_HI:0] == OP_SHIFT_LEFT) begin
      acc_reg <= {acc_reg[6:0], acc_reg[SIGN_BIT]}; // [RULE11]
    end else if (state_reg == ST_FETCH2 && op_reg == OP_ADD_IMMEDIATE) begin
      acc_reg <= oc_add(acc_reg, mem_rdata_i); // [RULE12]
    end else if (state_reg == ST_FETCH2 && op_reg == OP_SUBTRACT_IMMEDIATE) begin
      acc_reg <= oc_add(acc_reg, ~mem_rdata_i); // [RULE15] [RULE17]
    end else if (state_reg == ST_OPERAND) begin
      acc_reg <= oc_add(acc_reg, mem_rdata_i); // [RULE13]
    end
  end

  // program counter
  always_comb begin
    pc_next = pc_reg;
    if (state_reg == ST_FETCH1 || state_reg == ST_FETCH2) begin
      pc_next = pc_reg + 12'h001; // [RULE4]
    end else if (state_reg == ST_WAIT && taken && budget_reg == CYC_SHORT) begin
      pc_next = target; // [RULE8]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pc_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // memory request
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_reg <= 1'b1;
      addr_reg <= PC_RESET;
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      rd_reg <= 1'b0;
      unique case (state_reg)
        ST_FETCH1: begin
          if (mem_rdata_i[OP_HI:0] != OP_SHIFT_LEFT) begin
            rd_reg <= 1'b1;
            addr_reg <= pc_next;
          end
        end
        ST_FETCH2: begin
          if (op_reg == OP_ADD_INDIRECT) begin
            rd_reg <= 1'b1;
            addr_reg <= {4'h0, mem_rdata_i}; // [RULE14]
          end else if (op_reg == OP_ADD_DIRECT) begin
            rd_reg <= 1'b1;
            addr_reg <= {tag_val, mem_rdata_i}; // [RULE13]
          end
        end
        ST_POINTER: begin
          rd_reg <= 1'b1;
          addr_reg <= {tag_val, mem_rdata_i}; // [RULE14]
        end
        ST_OPERAND: begin
        end
        ST_WAIT: begin
          if (!(taken && budget_reg == CYC_SHORT) && cnt_reg + 12'h001 >= budget_reg) begin
            rd_reg <= 1'b1;
            addr_reg <= pc_next;
            done_reg <= 1'b1;
            illegal_reg <= !(is_cond_jump(op_reg) || op_reg == OP_JUMP_ALWAYS ||
              op_reg == OP_SHIFT_LEFT || op_reg == OP_ADD_IMMEDIATE ||
              op_reg == OP_ADD_DIRECT || op_reg == OP_ADD_INDIRECT ||
              op_reg == OP_SUBTRACT_IMMEDIATE);
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign mem_req_o = '{rd: rd_reg, addr: addr_reg};
  assign acc_o = acc_reg;
  assign pc_o = pc_reg;
  assign done_o = done_reg;
  assign illegal_o = illegal_reg;

  chk_shift_rotate: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE11]
    state_reg == ST_FETCH1 && mem_rdata_i[OP_HI:0] == OP_SHIFT_LEFT |=>
      acc_reg == {$past(acc_reg[6:0]), $past(acc_reg[7])})
    else $error("shift result wrong");
  chk_zero_jump: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE2]
    op_reg == OP_JUMP_IF_ZERO && acc_reg == 8'hFF |-> !taken)
    else $error("minus zero branched");
  chk_jump_target: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE3]
    state_reg == ST_WAIT && taken && budget_reg == CYC_SHORT |=> pc_reg == $past(target))
    else $error("jump target wrong");
  chk_no_tag_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE9]
    $past(tag_rd_sel) == 2'h0 |-> tag_val == 4'h0)
    else $error("tag zero not zero");
  chk_sign_jumps: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE6]
    op_reg == OP_JUMP_IF_POSITIVE |-> taken == !acc_reg[7])
    else $error("positive jump wrong");
  chk_neg_jump: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE7]
    op_reg == OP_JUMP_IF_NEGATIVE |-> taken == acc_reg[7])
    else $error("negative jump wrong");
  chk_nonzero_jump: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE5]
    op_reg == OP_JUMP_IF_NONZERO |-> taken == (acc_reg != 8'h00))
    else $error("nonzero jump wrong");
  chk_add_imm: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE12]
    state_reg == ST_FETCH2 && op_reg == OP_ADD_IMMEDIATE |=>
      acc_reg == oc_add($past(acc_reg), $past(mem_rdata_i)))
    else $error("add immediate wrong");

  // multi-step fetch sequences
  sequence s_two_word_fetch;
    state_reg == ST_FETCH1 && mem_rdata_i[OP_HI:0] != OP_SHIFT_LEFT ##1
      state_reg == ST_FETCH2;
  endsequence
  sequence s_indirect_pointer;
    state_reg == ST_FETCH2 && op_reg == OP_ADD_INDIRECT ##1
      state_reg == ST_POINTER;
  endsequence

  chk_pair_skip: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE4]
    s_two_word_fetch |=> pc_reg == $past(pc_reg, 2) + 12'h002)
    else $error("two word step wrong");
  chk_direct_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE13]
    state_reg == ST_FETCH2 && op_reg == OP_ADD_DIRECT |=>
      mem_req_o.rd && mem_req_o.addr == {tag_val, $past(mem_rdata_i)})
    else $error("direct operand address wrong");
  chk_indirect_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE14]
    s_indirect_pointer |-> mem_req_o.addr[11:8] == 4'h0 ##1
      mem_req_o.addr == {tag_val, $past(mem_rdata_i)})
    else $error("indirect operand address wrong");

  // instruction lengths at the end pulse
  chk_cond_time: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE10]
    done_reg && is_cond_jump(op_reg) |-> cnt_reg == (taken ? CYC_JUMP : CYC_SHORT))
    else $error("conditional jump time wrong");
  chk_jump_always: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE8]
    done_reg && op_reg == OP_JUMP_ALWAYS |-> cnt_reg == CYC_JUMP && pc_reg == target)
    else $error("unconditional jump wrong");
  chk_direct_time: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE13]
    done_reg && op_reg == OP_ADD_DIRECT |-> cnt_reg == CYC_MEM)
    else $error("direct add time wrong");
  chk_indirect_time: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE14]
    done_reg && op_reg == OP_ADD_INDIRECT |-> cnt_reg == CYC_IND)
    else $error("indirect add time wrong");
  chk_shift_time: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [RULE11]
    done_reg && op_reg == OP_SHIFT_LEFT |-> cnt_reg == CYC_SHORT)
    else $error("shift time wrong");
endmodule // jsa_exec
`default_nettype wire

/* test/jsa_core_mem.sv */
// Purpose: core memory model answering instruction and operand reads
// Assumes: read data stands while the request stands
// Notes: the bench loads words directly into mem
`timescale 1ns/10ps
`default_nettype none
module jsa_core_mem (
  input wire logic clk_sys_i,
  input wire jsa_pkg::jsa_mem_req_t req_i,
  output logic [7:0] rdata_o
);
  import jsa_pkg::*;
  logic [7:0] mem [4096];
  logic [7:0] last_reg;
  // outside a read the data lines toggle instead of holding
  assign rdata_o = req_i.rd ? mem[req_i.addr] : ~last_reg;
  always @(posedge clk_sys_i) begin
    if (req_i.rd) begin
      last_reg <= mem[req_i.addr];
    end else begin
      last_reg <= ~last_reg;
    end
  end
endmodule // jsa_core_mem
`default_nettype wire

/* test/jump_shift_add_execute_tb.sv */
// Purpose: self-checking bench for the jump/shift/add executor
// Assumes: one program run from word 0, tags loaded after reset
// Notes: each step checks fetch address and accumulator, and timing where a length is given
`timescale 1ns/10ps
`default_nettype none
module jump_shift_add_execute_tb;
  import jsa_pkg::*;
  localparam int NPROG = 35;
  localparam logic [19:0] PROG [NPROG] = '{
    20'h00030, 20'h00160, 20'h06031, 20'h06199, 20'h06272, 20'h06310,
    20'h41018, 20'h41152, 20'h41201, 20'h41301, 20'h4141C, 20'h41549,
    20'h41630, 20'h41710, 20'h418B3, 20'h41920, 20'hC2031, 20'hC2140,
    20'h04018, 20'h04101, 20'h04233, 20'h04300, 20'h04459, 20'h04523,
    20'h046DA, 20'h04722, 20'h048F4, 20'h04950, 20'h7503F, 20'h75100,
    20'h75234, 20'h75300, 20'h4237F, 20'h02213, 20'h71385};
  localparam logic [3:0] TAGS [4] = '{4'hF, 4'h4, 4'hC, 4'h7};
  logic clk_sys_i = 1'b0;
  logic rst_i;
  logic tag_wr_i;
  logic [1:0] tag_wr_sel_i;
  logic [3:0] tag_wr_data_i;
  logic [7:0] mem_rdata;
  jsa_mem_req_t mem_req;
  logic [7:0] acc;
  logic [11:0] pc;
  logic done;
  logic illegal;
  int num_errors = 0;
  int total_checks = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  jsa_exec i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .mem_rdata_i(mem_rdata),
    .tag_wr_i(tag_wr_i), .tag_wr_sel_i(tag_wr_sel_i),
    .tag_wr_data_i(tag_wr_data_i), .mem_req_o(mem_req), .acc_o(acc),
    .pc_o(pc), .done_o(done), .illegal_o(illegal));
  jsa_core_mem i_mem (.clk_sys_i(clk_sys_i), .req_i(mem_req), .rdata_o(mem_rdata));
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_time(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // waits for the end of one instruction and judges it
  task automatic step(input logic [11:0] pc_exp, input logic [7:0] acc_exp,
                      input logic [11:0] len, input logic ill_exp);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (done !== 1'b1 && n < 3000);
    chk_val(12'(done), 12'h001);
    chk_val(12'(mem_req.rd), 12'h001);
    chk_val(mem_req.addr, pc_exp);
    chk_val(pc, pc_exp);
    if (len != 12'h000) begin
      chk_time(n, int'(len));
    end
    chk_val({4'h0, acc}, {4'h0, acc_exp});
    chk_val(12'(illegal), 12'(ill_exp));
  endtask
  task test_zero_acc_jumps;
    step(12'h060, 8'h00, 12'h000, 1'b0);
    step(12'h062, 8'h00, CYC_SHORT, 1'b0);
    step(12'h410, 8'h00, CYC_JUMP, 1'b0);
  endtask
  task test_shift_minus_zero;
    step(12'h412, 8'h52, CYC_SHORT, 1'b0);
    step(12'h413, 8'hA4, CYC_SHORT, 1'b0);
    step(12'h414, 8'h49, CYC_SHORT, 1'b0);
    step(12'h416, 8'hFF, CYC_SHORT, 1'b0);
    step(12'h418, 8'hFF, CYC_SHORT, 1'b0);
  endtask
  task test_taken_jumps;
    step(12'hC20, 8'hFF, CYC_JUMP, 1'b0);
    step(12'h040, 8'hFF, CYC_JUMP, 1'b0);
    step(12'h042, 8'h01, CYC_SHORT, 1'b0);
    step(12'h044, 8'h01, CYC_SHORT, 1'b0);
  endtask
  task test_memory_adds;
    step(12'h046, 8'h80, CYC_MEM, 1'b0);
    step(12'h048, 8'h06, CYC_IND, 1'b0);
  endtask
  task test_jump_and_illegal;
    step(12'h750, 8'h06, CYC_JUMP, 1'b0);
    step(12'h752, 8'h06, CYC_SHORT, 1'b1);
  endtask
  initial begin
    rst_i <= 1'b1;
    tag_wr_i <= 1'b0;
    tag_wr_sel_i <= 2'h0;
    tag_wr_data_i <= 4'h0;
    for (int i = 0; i < NPROG; i++) begin
      i_mem.mem[PROG[i][19:8]] = PROG[i][7:0];
    end
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // tag 0 write must be ignored
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      tag_wr_i <= 1'b1;
      tag_wr_sel_i <= 2'(i);
      tag_wr_data_i <= TAGS[i];
    end
    @(posedge clk_sys_i);
    tag_wr_i <= 1'b0;
    test_zero_acc_jumps();
    test_shift_minus_zero();
    test_taken_jumps();
    test_memory_adds();
    test_jump_and_illegal();
    finish_test();
  end
  // program needs about 13000 cycles
  initial begin
    #400000;
    num_errors++;
    finish_test();
  end
endmodule // jump_shift_add_execute_tb
`default_nettype wire
